// *** hdl/porsq_params.svh ***
// Timing counts and strap field positions for the power-on reset sequencer.
// Assumes the system clock stands in for both the input clock and the bus reference clock.
`ifndef PORSQ_PARAMS_SVH
`define PORSQ_PARAMS_SVH

// Input clock cycles that the external power-on reset must be held at least.
`define PORSQ_MIN_POR_CYC 16
// Input clock cycles of internal power-on reset stretch.
`define PORSQ_STRETCH_CYC 1024
// Input clock cycles per reference cycle, before the divide factor, for PLL lock.
`define PORSQ_LOCK_CYC 6400
// Reference clock cycles from lock to hard reset release.
`define PORSQ_HARD_CYC 512
// Reference clock cycles from lock to soft reset release.
`define PORSQ_SOFT_CYC 515
// Counter width, wide enough for 6400 times a divide factor of up to 15.
`define PORSQ_CNT_W 17
// Strap vector width and field positions.
`define PORSQ_STRAP_W 14
`define PORSQ_STRAP_CFG 0
`define PORSQ_STRAP_SRC 1
`define PORSQ_STRAP_SYNC 2
`define PORSQ_STRAP_WIDE 3
`define PORSQ_STRAP_DEV_LSB 4
`define PORSQ_STRAP_BOOT_LSB 8
`define PORSQ_STRAP_WDOG 11
`define PORSQ_STRAP_CLK_LSB 12
// Built-in default configuration word.
`define PORSQ_DEFAULT_CFG 32'h0000_0000

`endif

// *** hdl/porsq_pkg.sv ***
// Types for the power-on reset sequencer.
// Assumes nothing of its surroundings.
package porsq_pkg;
    // One-hot sequence states.
    typedef enum logic [5:0] {
        ST_POR   = 6'h01,
        ST_STRCH = 6'h02,
        ST_LOCK  = 6'h04,
        ST_HARD  = 6'h08,
        ST_SOFT  = 6'h10,
        ST_RUN   = 6'h20
    } porsq_state_t;

    // Source of the reset configuration word.
    typedef enum logic [1:0] {
        SRC_SLAVE_PORT = 2'h0,
        SRC_BUS_MASTER = 2'h1,
        SRC_BUS_SLAVE  = 2'h2
    } porsq_src_t;
endpackage

// *** hdl/porsq_power_on_reset_sequencer.sv ***
// Power-on reset sequencer: stretches power-on reset, waits for PLL lock,
// releases hard then soft reset, captures straps and picks the configuration word.
// Assumes all inputs synchronous to i_sys_clk, which stands for both the input and reference clocks.
// Behaviour
// - Internal power-on reset stays asserted 1025 input clocks after the external one deasserts.
// - PLL lock is reached 6400 times the divide factor input clocks after internal reset release.
// - Hard reset is released 512 reference clocks after PLL lock.
// - Soft reset is released 515 reference clocks after PLL lock, three after hard reset.
// - Fourteen strap levels are captured when power-on reset deasserts.
// - The configuration word comes from the slave port or the system bus as master or slave.
// - As configuration slave with no word written, a built-in default word is applied.
// - Soft reset is asserted whenever hard reset is asserted.
// - An external soft reset is recognised only while the device asserts no reset.
// - Hard reset is open drain, only ever pulled low.
`timescale 1ns/1ps
`default_nettype none
`include "porsq_params.svh"

module porsq_power_on_reset_sequencer
    import porsq_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_power_on_reset_in_n,
    input wire logic [3:0] i_pll_ref_divide_factor,
    input wire logic i_reset_config_select,
    input wire logic i_config_source_select,
    input wire logic i_slave_port_sync_select,
    input wire logic i_slave_port_wide_select,
    input wire logic [3:0] i_device_select_code,
    input wire logic [2:0] i_boot_mode_select,
    input wire logic i_watchdog_enable_strap,
    input wire logic [1:0] i_clock_mode_strap,
    input wire logic i_hard_reset_line_in_n,
    input wire logic i_soft_reset_line_in_n,
    input wire logic i_cfg_slave_wr,
    input wire logic i_cfg_bus_wr,
    input wire logic [31:0] i_cfg_word,
    output logic o_internal_por,
    output logic o_pll_locked,
    output logic o_hard_reset_line_out_n,
    output logic o_hard_reset_line_oe,
    output logic o_soft_reset_line_out_n,
    output logic o_soft_reset_line_oe,
    output logic o_ext_soft_reset,
    output logic [`PORSQ_STRAP_W-1:0] o_straps,
    output logic [1:0] o_config_source,
    output logic o_config_valid,
    output logic [31:0] o_config_word
);

    porsq_state_t state;
    porsq_state_t next_state;
    logic [`PORSQ_CNT_W-1:0] cnt;
    logic [`PORSQ_CNT_W-1:0] next_cnt;
    logic [`PORSQ_CNT_W-1:0] lock_cyc;
    logic [`PORSQ_STRAP_W-1:0] strap_now;
    logic [`PORSQ_STRAP_W-1:0] next_straps;
    logic por_prev;
    logic hard_asserted;
    logic next_hard;
    logic soft_asserted;
    logic next_soft;
    logic next_int_por;
    logic next_locked;
    logic next_ext_soft;
    logic [1:0] next_src;
    logic next_cfg_valid;
    logic [31:0] next_cfg_word;
    logic [3:0] pll_ref_divide_factor;

    // A divide factor of zero is taken as one.
    assign pll_ref_divide_factor = (i_pll_ref_divide_factor == 4'h0) ? 4'h1 : i_pll_ref_divide_factor;
    assign lock_cyc = `PORSQ_CNT_W'(`PORSQ_LOCK_CYC * pll_ref_divide_factor);

    // Strap vector in field order.
    assign strap_now = {i_clock_mode_strap, i_watchdog_enable_strap, i_boot_mode_select,
                        i_device_select_code, i_slave_port_wide_select, i_slave_port_sync_select,
                        i_config_source_select, i_reset_config_select};

    // Sequence state and counter next values.
    always_comb begin
        next_state = state;
        next_cnt = cnt + `PORSQ_CNT_W'(1);
        if (!i_power_on_reset_in_n) begin
            next_state = ST_POR;
            next_cnt = '0;
        end else begin
            case (state)
                ST_POR: begin
                    next_state = ST_STRCH;
                    next_cnt = '0;
                end
                ST_STRCH: begin
                    if (cnt == `PORSQ_CNT_W'(`PORSQ_STRETCH_CYC - 1)) begin
                        next_state = ST_LOCK;
                        next_cnt = '0;
                    end
                end
                ST_LOCK: begin
                    if (cnt == lock_cyc - `PORSQ_CNT_W'(1)) begin
                        next_state = ST_HARD;
                        next_cnt = '0;
                    end
                end
                ST_HARD: begin
                    if (cnt == `PORSQ_CNT_W'(`PORSQ_HARD_CYC - 1)) begin
                        next_state = ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (cnt == `PORSQ_CNT_W'(`PORSQ_SOFT_CYC - 1)) begin
                        next_state = ST_RUN;
                        next_cnt = '0;
                    end
                end
                ST_RUN: begin
                    next_cnt = '0;
                end
                default: begin
                    next_state = ST_POR;
                    next_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_POR;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Reset line drive, derived from the next state so outputs stay registered.
    always_comb begin
        next_int_por = (next_state == ST_POR) || (next_state == ST_STRCH);
        next_locked = (next_state == ST_HARD) || (next_state == ST_SOFT) || (next_state == ST_RUN);
        next_hard = (next_state != ST_SOFT) && (next_state != ST_RUN);
        next_soft = next_hard || (next_state == ST_SOFT);
        next_ext_soft = !next_soft && !i_soft_reset_line_in_n && i_hard_reset_line_in_n;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_internal_por <= 1'b1;
            o_pll_locked <= 1'b0;
            hard_asserted <= 1'b1;
            soft_asserted <= 1'b1;
            o_ext_soft_reset <= 1'b0;
        end else begin
            o_internal_por <= next_int_por;
            o_pll_locked <= next_locked;
            hard_asserted <= next_hard;
            soft_asserted <= next_soft;
            o_ext_soft_reset <= next_ext_soft;
        end
    end

    // Open-drain pins: value is always low, only the enable moves.
    assign o_hard_reset_line_out_n = 1'b0;
    assign o_hard_reset_line_oe = hard_asserted;
    assign o_soft_reset_line_out_n = 1'b0;
    assign o_soft_reset_line_oe = soft_asserted;

    // Strap capture on the rising edge of the power-on reset input.
    always_comb begin
        next_straps = o_straps;
        if (i_power_on_reset_in_n && !por_prev) begin
            next_straps = strap_now;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            por_prev <= 1'b0;
            o_straps <= '0;
        end else begin
            por_prev <= i_power_on_reset_in_n;
            o_straps <= next_straps;
        end
    end

    // Configuration source and word selection.
    always_comb begin
        next_src = o_config_source;
        next_cfg_valid = o_config_valid;
        next_cfg_word = o_config_word;
        if (!i_power_on_reset_in_n) begin
            next_cfg_valid = 1'b0;
            next_cfg_word = `PORSQ_DEFAULT_CFG;
        end else if (i_power_on_reset_in_n && !por_prev) begin
            if (!strap_now[`PORSQ_STRAP_CFG]) begin
                next_src = SRC_SLAVE_PORT;
            end else if (strap_now[`PORSQ_STRAP_SRC]) begin
                next_src = SRC_BUS_MASTER;
            end else begin
                next_src = SRC_BUS_SLAVE;
            end
        end else if (!o_config_valid) begin
            if (o_config_source == SRC_SLAVE_PORT && i_cfg_slave_wr) begin
                next_cfg_word = i_cfg_word;
                next_cfg_valid = 1'b1;
            end else if (o_config_source != SRC_SLAVE_PORT && i_cfg_bus_wr && hard_asserted) begin
                next_cfg_word = i_cfg_word;
                next_cfg_valid = 1'b1;
            end else if (state == ST_HARD && cnt == `PORSQ_CNT_W'(`PORSQ_HARD_CYC - 1)) begin
                if (o_config_source == SRC_BUS_SLAVE) begin
                    next_cfg_word = `PORSQ_DEFAULT_CFG;
                end
                next_cfg_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_config_source <= SRC_SLAVE_PORT;
            o_config_valid <= 1'b0;
            o_config_word <= `PORSQ_DEFAULT_CFG;
        end else begin
            o_config_source <= next_src;
            o_config_valid <= next_cfg_valid;
            o_config_word <= next_cfg_word;
        end
    end

endmodule

`default_nettype wire

// *** verif/porsq_board_model.sv ***
// Board supervisor model: drives the power-on reset input and resolves both reset lines.
// Assumes the bench pulses i_start at a falling edge and runs everything off i_sys_clk.
`timescale 1ns/1ps
`default_nettype none

module porsq_board_model (
    input wire logic i_sys_clk,
    input wire logic i_start,
    input wire logic i_soft_pull,
    input wire logic i_hard_oe,
    input wire logic i_soft_oe,
    output logic o_por_n,
    output logic o_hard_n,
    output logic o_soft_n
);
    logic [4:0] hold = 5'h10;

    // Holds power-on reset low for sixteen cycles at power-up and after each start.
    // It moves on the rising edge, so the sequencer sees the old level there and the bench a settled one.
    always @(posedge i_sys_clk) begin
        if (i_start) begin
            hold <= 5'h10;
        end else if (hold != 5'h00) begin
            hold <= hold - 5'h01;
        end
    end
    assign o_por_n = (hold == 5'h00);
    // Both lines have pull-ups, so a line is low only while some party pulls it.
    assign o_hard_n = !i_hard_oe;
    assign o_soft_n = !(i_soft_oe || i_soft_pull);
endmodule

`default_nettype wire

// *** verif/porsq_reset_properties.sv ***
// Checker for the power-on reset sequencer, bound to its top module.
// Assumes power-on reset is low while i_rst is released.
`timescale 1ns/1ps
`default_nettype none
`include "porsq_params.svh"

module porsq_reset_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_power_on_reset_in_n,
    input wire logic [3:0] i_pll_ref_divide_factor,
    input wire logic i_reset_config_select,
    input wire logic i_config_source_select,
    input wire logic o_internal_por,
    input wire logic o_pll_locked,
    input wire logic o_hard_reset_line_out_n,
    input wire logic o_hard_reset_line_oe,
    input wire logic o_soft_reset_line_oe,
    input wire logic o_ext_soft_reset,
    input wire logic [1:0] o_config_source
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [17:0] cyc;
    logic [17:0] next_cyc;
    logic [17:0] lock_at;

    // Counts edges since power-on reset rose; a divide factor of 0 counts as 1.
    always_comb next_cyc = i_power_on_reset_in_n ? cyc + 18'h00001 : 18'h00000;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cyc <= 18'h00000;
        end else begin
            cyc <= next_cyc;
        end
    end
    assign lock_at = 18'(`PORSQ_STRETCH_CYC + 1 + `PORSQ_LOCK_CYC * ((i_pll_ref_divide_factor == 4'h0) ? 18'h00001
        : {14'h0000, i_pll_ref_divide_factor}));

    stretch_len_a: assert property ($fell(o_internal_por) |-> cyc == `PORSQ_STRETCH_CYC + 1)
        else $error("internal reset length wrong");
    lock_time_a: assert property ($rose(o_pll_locked) |-> cyc == lock_at)
        else $error("lock time wrong");
    hard_time_a: assert property ($fell(o_hard_reset_line_oe) |-> cyc == lock_at + `PORSQ_HARD_CYC)
        else $error("hard release time wrong");
    soft_gap_a: assert property ($fell(o_hard_reset_line_oe) |-> o_soft_reset_line_oe [*3] ##1 !o_soft_reset_line_oe)
        else $error("soft release gap wrong");
    hard_soft_a: assert property (o_hard_reset_line_oe |-> o_soft_reset_line_oe)
        else $error("hard without soft");
    por_drive_a: assert property (!i_power_on_reset_in_n |=> o_internal_por && o_hard_reset_line_oe
        && o_soft_reset_line_oe && !o_pll_locked)
        else $error("resets not held");
    open_drain_a: assert property (!o_hard_reset_line_out_n)
        else $error("hard line driven high");
    ext_soft_a: assert property (o_ext_soft_reset |-> !o_hard_reset_line_oe && !o_soft_reset_line_oe)
        else $error("soft seen while resetting");
    source_map_a: assert property ($rose(i_power_on_reset_in_n) |=> o_config_source == (!$past(i_reset_config_select)
        ? 2'h0 : ($past(i_config_source_select) ? 2'h1 : 2'h2)))
        else $error("config source wrong");
endmodule

bind porsq_power_on_reset_sequencer porsq_reset_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_power_on_reset_in_n(i_power_on_reset_in_n), .i_pll_ref_divide_factor(i_pll_ref_divide_factor),
    .i_reset_config_select(i_reset_config_select), .i_config_source_select(i_config_source_select),
    .o_internal_por(o_internal_por), .o_pll_locked(o_pll_locked), .o_hard_reset_line_out_n(o_hard_reset_line_out_n),
    .o_hard_reset_line_oe(o_hard_reset_line_oe), .o_soft_reset_line_oe(o_soft_reset_line_oe),
    .o_ext_soft_reset(o_ext_soft_reset), .o_config_source(o_config_source));

`default_nettype wire

// *** verif/porsq_power_on_reset_sequencer_test.sv ***
// Testbench: power-on sequences for each configuration source, with timing and word checks.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "porsq_params.svh"

module porsq_power_on_reset_sequencer_test;
    logic clk;
    logic rst = 1'b1, start = 1'b0, pull = 1'b0, csw = 1'b0, cbw = 1'b0;
    logic [3:0] pll_ref_divide_factor = 4'h1;
    logic [13:0] strap = 14'h0000;
    logic [31:0] word = 32'h00000000;
    wire logic por_n, hard_n, soft_n, hoe, soe, xsr, val;
    wire logic [13:0] st;
    wire logic [1:0] src;
    wire logic [31:0] cw;
    int error_cnt = 0, tests_run = 0, cyc = 0;

    porsq_power_on_reset_sequencer dut (.i_sys_clk(clk), .i_rst(rst), .i_power_on_reset_in_n(por_n),
        .i_pll_ref_divide_factor(pll_ref_divide_factor), .i_reset_config_select(strap[0]), .i_config_source_select(strap[1]),
        .i_slave_port_sync_select(strap[2]), .i_slave_port_wide_select(strap[3]), .i_device_select_code(strap[7:4]),
        .i_boot_mode_select(strap[10:8]), .i_watchdog_enable_strap(strap[11]), .i_clock_mode_strap(strap[13:12]),
        .i_hard_reset_line_in_n(hard_n), .i_soft_reset_line_in_n(soft_n), .i_cfg_slave_wr(csw), .i_cfg_bus_wr(cbw),
        .i_cfg_word(word), .o_internal_por(), .o_pll_locked(), .o_hard_reset_line_out_n(), .o_hard_reset_line_oe(hoe),
        .o_soft_reset_line_out_n(), .o_soft_reset_line_oe(soe), .o_ext_soft_reset(xsr), .o_straps(st),
        .o_config_source(src), .o_config_valid(val), .o_config_word(cw));
    porsq_board_model board (.i_sys_clk(clk), .i_start(start), .i_soft_pull(pull), .i_hard_oe(hoe),
        .i_soft_oe(soe), .o_por_n(por_n), .o_hard_n(hard_n), .o_soft_n(soft_n));

    // Clock at 50 MHz.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step();
        @(negedge clk);
        cyc++;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One power-on sequence; wr sends a slave-port word then a bus word.
    task automatic run_seq(input logic [13:0] s, input logic [3:0] r, input logic wr, input logic [31:0] exp);
        int t;
        t = 1538 + 6400 * ((r == 4'h0) ? 1 : r);
        strap = s;
        pll_ref_divide_factor = r;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while (!por_n) @(negedge clk);
        cyc = 1;
        step();
        step();
        strap = ~s;
        chk("straps", s, st);
        chk("source", !s[0] ? 0 : (s[1] ? 1 : 2), src);
        pull = 1'b1;
        step();
        chk("busy soft", 0, xsr);
        pull = 1'b0;
        if (wr) begin
            csw = 1'b1;
            word = 32'hA5A50001;
            step();
            csw = 1'b0;
            cbw = 1'b1;
            word = 32'h5A5A0002;
            step();
            cbw = 0;
        end
        while (hoe === 1'b1 && cyc < 200000) step();
        chk("hard release", t, cyc);
        chk("valid", 1, val);
        chk("word", exp, cw);
        while (soe === 1'b1 && cyc < 200000) step();
        chk("soft release", t + 3, cyc);
        pull = 1'b1;
        repeat (4) step();
        chk("ext soft", 1, xsr);
        pull = 1'b0;
        step();
        $display("test done straps %h", s);
    endtask

    // Slave port, bus master and bus slave without a write.
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        run_seq(14'h1A5C, 4'h1, 1'b1, 32'hA5A50001);
        run_seq(14'h25A3, 4'h2, 1'b1, 32'h5A5A0002);
        run_seq(14'h3C01, 4'h0, 1'b0, `PORSQ_DEFAULT_CFG);
        end_sim();
    end

    // Watchdog for a hung sequence.
    initial begin
        #(60000 * 20);
        error_cnt++;
        $display("BAD watchdog expected finish seen hang");
        end_sim();
    end
endmodule

`default_nettype wire
